// ==== common/swl_map.vh ====
// register map, command codes and line timing for the single-wire port
// assumes a 100 MHz core clock
`ifndef SWL_MAP_VH
`define SWL_MAP_VH
`define SWL_CLK_HZ        100000000
`define SWL_ADDR_PAGE1    7'h20
`define SWL_ADDR_PAGE2    7'h40
`define SWL_ADDR_SFR      7'h60
`define SWL_ADDR_FLASH_COMMAND     7'h62
`define SWL_ADDR_CLR      7'h63
`define SWL_ADDR_MODE     7'h64
`define SWL_ADDR_CTCL     7'h65
`define SWL_ADDR_CTCH     7'h66
`define SWL_ADDR_DTCL     7'h67
`define SWL_ADDR_DTCH     7'h68
`define SWL_ADDR_FPD      7'h6f
`define SWL_ADDR_FPA      7'h70
`define SWL_ADDR_VLOW     7'h71
`define SWL_ADDR_VHIGH    7'h72
`define SWL_CMD_PROGRAM   8'h0f
`define SWL_CMD_ERASE0    8'h40
`define SWL_CMD_ERASE1    8'h41
`define SWL_CMD_ERASE2    8'h42
`define SWL_CMD_RAM2FL    8'h45
`define SWL_CMD_FL2RAM    8'h48
`define SWL_CMD_PWRDN     8'hf6
`define SWL_BYTE_ERASED   8'hff
`define SWL_CLR_CTC       4
`define SWL_CLR_DTC       3
`define SWL_MODE_STC      5
`define SWL_MODE_STD      4
`define SWL_MODE_RESET    8'h4f
// line timing in microseconds, glitch filter in cycles, counter rate in milliseconds
`define SWL_BREAK_US      190
`define SWL_BREAK_REC_US  40
`define SWL_SAMPLE_US     100
`define SWL_DEV_START_US  40
`define SWL_DEV_HOLD_US   150
`define SWL_DEV_CYCLE_US  200
`define SWL_TURN_US       200
`define SWL_GLITCH_CYC    4
`define SWL_RATE_MS       879
`endif

// ==== hw/swl_port.v ====
// single-wire host port with flash command sequencer and counter clear
// assumes external pull-up on the line; line input is asynchronous
// Notes on behaviour
// RQ1: codes 0x40/0x41/0x42 erase flash page 0, 1 or 2.
// RQ2: 0x45 copies RAM page 0 to flash page 0; 0x48 copies back.
// RQ3: code 0xF6 enters low power mode.
// RQ4: program data, program address, then 0x0F at 0x62 programs a byte.
// RQ5: byte program stores data AND old flash byte.
// RQ6: RAM-to-flash stores old flash AND RAM per byte.
// RQ7: host erases a page before rewriting and restores needed bytes.
// RQ8: user pages program per byte; shadow page also by page transfer.
// RQ9: command byte first; write stores next byte, read sends a byte.
// RQ10: bytes go eight bits, least significant bit first.
// RQ11: at most 5 kbit/s, return-to-one, line idles high.
// RQ12: low for break time is a break; after recovery a command is taken.
// RQ13: host sends a break on first access or after a timeout.
// RQ14: bit frame: start low, hold value to sample, release high to cycle end.
// RQ15: command bit 7 is the write flag, bits 6..0 the address.
// RQ16: a read drives the addressed register onto the line.
// RQ17: writing 1 to a clear bit zeroes the counter; bit self-clears.
// RQ18: clearing discharge time also clears rollover and resets rate.
// RQ19: clearing charge time also clears rollover and resets rate.
// RQ20: voltage high bits 7..3 hold sign-magnitude offset, 8 mV steps.
// RQ21: voltage is 11 bits: low byte at 0x71, three bits in high byte.
// RQ22: program address at 0x70 and program data at 0x6F.
// RQ23: page 1 at 0x20-0x3F, page 2 at 0x40-0x5F, page 0 RAM at 0x00.
// RQ24: power-on reset copies flash page 0 into RAM page 0.
// RQ25: line timed on internal clock; glitches below a few cycles ignored.
`timescale 1ns/1ns
`include "swl_map.vh"
module swl_port #(
  parameter BREAK_CYC   = `SWL_BREAK_US * (`SWL_CLK_HZ / 1000000),
  parameter BREC_CYC    = `SWL_BREAK_REC_US * (`SWL_CLK_HZ / 1000000),
  parameter SAMPLE_CYC  = `SWL_SAMPLE_US * (`SWL_CLK_HZ / 1000000),
  parameter DSTART_CYC  = `SWL_DEV_START_US * (`SWL_CLK_HZ / 1000000),
  parameter DHOLD_CYC   = `SWL_DEV_HOLD_US * (`SWL_CLK_HZ / 1000000),
  parameter DCYCLE_CYC  = `SWL_DEV_CYCLE_US * (`SWL_CLK_HZ / 1000000),
  parameter TURN_CYC    = `SWL_TURN_US * (`SWL_CLK_HZ / 1000000),
  parameter RATE_CYC    = `SWL_RATE_MS * (`SWL_CLK_HZ / 1000),
  parameter [7:0] OFFSET_VAL = 8'h00
) (
  input  wire        ref_clk,     // 100 MHz core clock
  input  wire        rst,         // async reset, acts as power-on reset
  input  wire        lineIn,      // single-wire line level
  output reg         lineOut,     // drive value, always low when driving
  output reg         lineOe_n,    // low while device pulls the line
  input  wire [10:0] voltageIn,   // converter result
  input  wire        discharging, // discharge activity
  input  wire        charging,    // charge activity
  output reg         powerDown    // low power mode request
);
  localparam S_IDLE = 3'h0, S_RXLOW = 3'h1, S_RXHIGH = 3'h2, S_TXGAP = 3'h3, S_TX = 3'h4, S_BREAK = 3'h5;
  localparam F_IDLE = 2'h0, F_RUN = 2'h1;
  localparam OP_NONE = 3'h0, OP_ERASE = 3'h1, OP_R2F = 3'h2, OP_F2R = 3'h3;
  reg [7:0] ram [0:31];
  reg [7:0] flash [0:95];
  reg [1:0] lineSync;
  reg [2:0] glitchCnt;
  reg       lineF;
  reg [2:0] state;
  reg [31:0] timer;
  reg [3:0] bitCnt;
  reg [7:0] shift;
  reg       haveCmd;
  reg [7:0] cmd;
  reg [7:0] txByte;
  reg [7:0] flashCmd, progData, progAddr, clearReg, modeReg;
  reg [15:0] charge_time_counter, discharge_time_counter;
  reg [31:0] ctcPre, dtcPre;
  reg [1:0] fstate;
  reg [2:0] fop;
  reg [6:0] fbase;
  reg [4:0] fidx;
  reg [7:0] rdData;
  reg       bootDone;
  integer   i;

  function [7:0] read_reg;
    input [6:0] a;
    begin
      case (a)
        `SWL_ADDR_FLASH_COMMAND:  read_reg = flashCmd;
        `SWL_ADDR_CLR:   read_reg = clearReg;
        `SWL_ADDR_MODE:  read_reg = modeReg;
        `SWL_ADDR_CTCL:  read_reg = charge_time_counter[7:0];
        `SWL_ADDR_CTCH:  read_reg = charge_time_counter[15:8];
        `SWL_ADDR_DTCL:  read_reg = discharge_time_counter[7:0];
        `SWL_ADDR_DTCH:  read_reg = discharge_time_counter[15:8];
        `SWL_ADDR_FPD:   read_reg = progData;
        `SWL_ADDR_FPA:   read_reg = progAddr;
        `SWL_ADDR_VLOW:  read_reg = voltageIn[7:0];                       // [RQ21]
        `SWL_ADDR_VHIGH: read_reg = {OFFSET_VAL[7:3], voltageIn[10:8]};  // [RQ20] [RQ21]
        default: begin
          if (a < `SWL_ADDR_PAGE1)
            read_reg = ram[a[4:0]];                                       // [RQ23]
          else if (a < `SWL_ADDR_SFR)
            read_reg = flash[a];                                          // [RQ23]
          else
            read_reg = 8'h00;
        end
      endcase
    end
  endfunction

  // two-flop sync then glitch filter
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lineSync  <= 2'h3;
      glitchCnt <= 3'h0;
      lineF     <= 1'b1;
    end else begin
      lineSync <= {lineSync[0], lineIn};
      if (lineSync[1] == lineF)
        glitchCnt <= 3'h0;
      else if (glitchCnt == `SWL_GLITCH_CYC - 1) begin
        glitchCnt <= 3'h0;
        lineF     <= lineSync[1];                                         // [RQ25]
      end else
        glitchCnt <= glitchCnt + 3'h1;
    end
  end

  wire fire = (state == S_RXHIGH) && lineF && (bitCnt == 4'h8) && haveCmd && cmd[7];

  // line engine
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= S_BREAK; timer <= 32'h0; bitCnt <= 4'h0; shift <= 8'h0;
      haveCmd <= 1'b0; cmd <= 8'h0; txByte <= 8'h0;
      lineOut <= 1'b0; lineOe_n <= 1'b1;
    end else begin
      lineOut <= 1'b0;
      case (state)
        S_BREAK: begin
          lineOe_n <= 1'b1;
          haveCmd <= 1'b0; bitCnt <= 4'h0;
          if (!lineF) timer <= 32'h0;
          else if (timer == BREC_CYC - 1) begin
            state <= S_IDLE; timer <= 32'h0;                              // [RQ12]
          end else timer <= timer + 32'h1;
        end
        S_IDLE, S_RXHIGH: begin
          lineOe_n <= 1'b1;
          if (state == S_RXHIGH && bitCnt == 4'h8) begin
            bitCnt <= 4'h0;
            if (!haveCmd) begin
              cmd <= shift;
              if (shift[7]) begin haveCmd <= 1'b1; state <= S_IDLE; end  // [RQ15] [RQ9]
              else begin
                txByte <= read_reg(shift[6:0]);                           // [RQ16]
                state <= S_TXGAP; timer <= 32'h0;
              end
            end else begin
              haveCmd <= 1'b0; state <= S_IDLE;                           // [RQ9]
            end
          end else if (!lineF) begin
            state <= S_RXLOW; timer <= 32'h0;                             // [RQ14]
          end
        end
        S_RXLOW: begin
          timer <= timer + 32'h1;
          if (timer == SAMPLE_CYC - 1)
            shift <= {lineF, shift[7:1]};                                 // [RQ10] [RQ14]
          if (timer >= BREAK_CYC - 1) begin
            state <= S_BREAK; timer <= 32'h0;                             // [RQ12]
          end else if (lineF && timer >= SAMPLE_CYC) begin
            state <= S_RXHIGH; bitCnt <= bitCnt + 4'h1;
          end
        end
        S_TXGAP: begin
          lineOe_n <= 1'b1;
          if (!lineF) begin state <= S_RXLOW; timer <= 32'h0; end
          else if (timer == TURN_CYC - 1) begin
            state <= S_TX; timer <= 32'h0;
          end else timer <= timer + 32'h1;
        end
        S_TX: begin
          // start low, bit value to hold time, then high to cycle end
          lineOe_n <= !(timer < DSTART_CYC || (timer < DHOLD_CYC && !txByte[bitCnt[2:0]])); // [RQ14] [RQ10] [RQ11]
          if (timer == DCYCLE_CYC - 1) begin
            timer <= 32'h0;
            if (bitCnt == 4'h7) begin
              bitCnt <= 4'h0; state <= S_IDLE;
            end else bitCnt <= bitCnt + 4'h1;
          end else timer <= timer + 32'h1;
        end
        default: state <= S_BREAK;
      endcase
    end
  end

  // register writes, flash sequencer and time counters
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flashCmd <= 8'h0; progData <= 8'h0; progAddr <= 8'h0;
      clearReg <= 8'h0; modeReg <= `SWL_MODE_RESET;
      charge_time_counter <= 16'h0; discharge_time_counter <= 16'h0; ctcPre <= 32'h0; dtcPre <= 32'h0;
      fstate <= F_RUN; fop <= OP_F2R; fbase <= 7'h0; fidx <= 5'h0;       // [RQ24]
      powerDown <= 1'b0; bootDone <= 1'b0;
    end else begin
      // counters advance; each rollover toggles the x256 slow rate, handled as prescaler growth
      if (charging) begin
        if (ctcPre >= (modeReg[`SWL_MODE_STC] ? RATE_CYC * 256 - 1 : RATE_CYC - 1)) begin
          ctcPre <= 32'h0; charge_time_counter <= charge_time_counter + 16'h1;
          if (charge_time_counter == 16'hffff) modeReg[`SWL_MODE_STC] <= !modeReg[`SWL_MODE_STC];
        end else ctcPre <= ctcPre + 32'h1;
      end
      if (discharging) begin
        if (dtcPre >= (modeReg[`SWL_MODE_STD] ? RATE_CYC * 256 - 1 : RATE_CYC - 1)) begin
          dtcPre <= 32'h0; discharge_time_counter <= discharge_time_counter + 16'h1;
          if (discharge_time_counter == 16'hffff) modeReg[`SWL_MODE_STD] <= !modeReg[`SWL_MODE_STD];
        end else dtcPre <= dtcPre + 32'h1;
      end
      if (clearReg[`SWL_CLR_CTC]) begin
        charge_time_counter <= 16'h0; ctcPre <= 32'h0; modeReg[`SWL_MODE_STC] <= 1'b0;   // [RQ17] [RQ19]
        clearReg[`SWL_CLR_CTC] <= 1'b0;                                   // [RQ17]
      end
      if (clearReg[`SWL_CLR_DTC]) begin
        discharge_time_counter <= 16'h0; dtcPre <= 32'h0; modeReg[`SWL_MODE_STD] <= 1'b0;   // [RQ17] [RQ18]
        clearReg[`SWL_CLR_DTC] <= 1'b0;                                   // [RQ17]
      end
      if (fire) begin
        powerDown <= 1'b0;
        case (cmd[6:0])
          `SWL_ADDR_FLASH_COMMAND: begin
            flashCmd <= shift;
            if (fstate == F_IDLE) begin
              case (shift)
                `SWL_CMD_PROGRAM: if (progAddr[6:0] < `SWL_ADDR_SFR)
                  flash[progAddr[6:0]] <= flash[progAddr[6:0]] & progData; // [RQ4] [RQ5] [RQ8] [RQ22]
                `SWL_CMD_ERASE0, `SWL_CMD_ERASE1, `SWL_CMD_ERASE2: begin
                  fstate <= F_RUN; fop <= OP_ERASE; fidx <= 5'h0;
                  fbase <= {shift[1:0], 5'h0};                            // [RQ1]
                end
                `SWL_CMD_RAM2FL: begin fstate <= F_RUN; fop <= OP_R2F; fidx <= 5'h0; fbase <= 7'h0; end // [RQ2]
                `SWL_CMD_FL2RAM: begin fstate <= F_RUN; fop <= OP_F2R; fidx <= 5'h0; fbase <= 7'h0; end // [RQ2]
                `SWL_CMD_PWRDN:  powerDown <= 1'b1;                        // [RQ3]
                default: ;
              endcase
            end
          end
          `SWL_ADDR_CLR:  clearReg <= shift & 8'h1f;
          `SWL_ADDR_MODE: modeReg <= shift;
          `SWL_ADDR_FPD:  progData <= shift;                               // [RQ22]
          `SWL_ADDR_FPA:  progAddr <= shift;                               // [RQ22]
          default: if (cmd[6:0] < `SWL_ADDR_PAGE1) ram[cmd[4:0]] <= shift;
        endcase
      end else if (fstate == F_RUN) begin
        case (fop)
          OP_ERASE: flash[fbase + {2'h0, fidx}] <= `SWL_BYTE_ERASED;         // [RQ1]
          OP_R2F:   flash[{2'h0, fidx}] <= flash[{2'h0, fidx}] & ram[fidx]; // [RQ6] [RQ8]
          OP_F2R:   ram[fidx] <= bootDone ? flash[{2'h0, fidx}] : flash[{2'h0, fidx}]; // [RQ24]
          default: ;
        endcase
        fidx <= fidx + 5'h1;
        if (fidx == 5'h1f) begin fstate <= F_IDLE; fop <= OP_NONE; bootDone <= 1'b1; end
      end
    end
  end

  initial begin
    for (i = 0; i < 96; i = i + 1) flash[i] = `SWL_BYTE_ERASED;
  end
endmodule

// ==== verification/swl_monitor.sv ====
// pin checker for the single-wire port
// assumes line times are scaled to ref_clk cycles
`timescale 1ns/1ns
module swl_monitor #(
  parameter DSTART_CYC = 40,
  parameter DHOLD_CYC  = 150,
  parameter DCYCLE_CYC = 200
) (
  input wire ref_clk,   // core clock
  input wire rst,       // async reset
  input wire lineIn,    // line level
  input wire lineOut,   // drive value
  input wire lineOe_n,  // drive enable
  input wire powerDown  // low power request
);
  reg [15:0] lowCnt;
  reg [15:0] highCnt;
  reg [15:0] sinceFall;
  wire       firstLow = !lineOe_n && lowCnt == 16'h0000;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lowCnt    <= 16'h0000;
      highCnt   <= 16'hffff;
      sinceFall <= 16'hffff;
    end else begin
      lowCnt    <= lineOe_n ? 16'h0000 : lowCnt + 16'h0001;
      highCnt   <= !lineIn ? 16'h0000 : highCnt + {15'h0000, highCnt != 16'hffff};
      sinceFall <= firstLow ? 16'h0000 : sinceFall + {15'h0000, sinceFall != 16'hffff};
    end
  end
  drive_zero_a: assert property (@(posedge ref_clk) disable iff (rst) !lineOe_n |-> !lineOut)
    else $error("device drove the line high");
  reset_quiet_a: assert property (@(posedge ref_clk) rst |-> lineOe_n && !powerDown)
    else $error("outputs active in reset");
  reset_wait_a: assert property (@(posedge ref_clk) $fell(rst) |-> lineOe_n [*8])
    else $error("line driven right after reset");
  bit_width_a: assert property (@(posedge ref_clk) disable iff (rst) $rose(lineOe_n) |->
    (lowCnt >= DSTART_CYC - 2 && lowCnt <= DSTART_CYC + 2) ||
    (lowCnt >= DHOLD_CYC - 2 && lowCnt <= DHOLD_CYC + 2)) else $error("device low time wrong");
  bit_cycle_a: assert property (@(posedge ref_clk) disable iff (rst) firstLow |-> sinceFall >= DCYCLE_CYC - 2)
    else $error("device bits too close");
  idle_before_a: assert property (@(posedge ref_clk) disable iff (rst)
    firstLow |-> highCnt >= DCYCLE_CYC - DHOLD_CYC - 3) else $error("device started on a low line");
  pd_set_a: assert property (@(posedge ref_clk) disable iff (rst) $rose(powerDown) |-> lineIn && lineOe_n)
    else $error("power down set mid frame");
  pd_clear_a: assert property (@(posedge ref_clk) disable iff (rst) $fell(powerDown) |-> $past(lineIn, 2))
    else $error("power down cleared mid frame");
endmodule

// ==== verification/swl_host_model.sv ====
// host side of the single-wire line: bit frames, break, answer capture
// assumes one ref_clk cycle per scaled microsecond and a pull-up on the line
`timescale 1ns/1ns
module swl_host_model (
  input  wire ref_clk,  // core clock
  input  wire lineIn,   // resolved line level
  output reg  hostPull  // high while host pulls the line low
);
  initial hostPull = 1'b0;
  task hold(input integer n, input v);
    begin
      hostPull = v;
      repeat (n) @(negedge ref_clk);
    end
  endtask
  task brk;
    begin
      hold(250, 1'b1);
      hold(60, 1'b0);
    end
  endtask
  task sendByte(input [7:0] b, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        hold(b[i] ? 30 : 160, 1'b1);
        hold(b[i] ? 175 : 45, 1'b0);
      end
    end
  endtask
  task getByte(output [7:0] b, output ok);
    integer i;
    integer t;
    begin
      ok = 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
        t = 0;
        while (lineIn && t < 600) begin
          @(negedge ref_clk);
          t = t + 1;
        end
        if (t >= 600) ok = 1'b0;
        repeat (95) @(negedge ref_clk);
        b[i] = lineIn;
        repeat (80) @(negedge ref_clk);
      end
    end
  endtask
endmodule

// ==== verification/single_wire_host_port_flash_cmd_test.sv ====
// self-checking bench for the single-wire port
// assumes scaled line timing and a pull-up on the line
`timescale 1ns/1ns
module single_wire_host_port_flash_cmd_test;
  reg         ref_clk = 1'b0;
  reg         rst = 1'b0;
  reg         charging = 1'b1;
  reg         discharging = 1'b1;
  reg  [10:0] voltageIn = 11'h000;
  reg  [31:0] seed = 32'h4ecbb3d2;
  reg  [7:0]  a;
  reg  [7:0]  b;
  wire        lineOut;
  wire        lineOe_n;
  wire        powerDown;
  wire        hostPull;
  wire        lineIn = !(hostPull || !lineOe_n);
  integer     num_errors = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  // line times shortened to one cycle per microsecond
  localparam  T_BREAK  = 190;
  localparam  T_BREC   = 40;
  localparam  T_SAMPLE = 100;
  localparam  T_DSTART = 40;
  localparam  T_DHOLD  = 150;
  localparam  T_DCYCLE = 200;
  localparam  T_TURN   = 200;
  localparam  T_RATE   = 1000;
  localparam  [7:0] T_OFFSET = 8'h98;
  always #5 ref_clk = ~ref_clk;
  swl_port #(.BREAK_CYC(T_BREAK), .BREC_CYC(T_BREC), .SAMPLE_CYC(T_SAMPLE), .DSTART_CYC(T_DSTART),
    .DHOLD_CYC(T_DHOLD), .DCYCLE_CYC(T_DCYCLE), .TURN_CYC(T_TURN), .RATE_CYC(T_RATE),
    .OFFSET_VAL(T_OFFSET)) swl_port_i (
    .ref_clk(ref_clk), .rst(rst), .lineIn(lineIn), .lineOut(lineOut), .lineOe_n(lineOe_n),
    .voltageIn(voltageIn), .discharging(discharging), .charging(charging), .powerDown(powerDown));
  swl_host_model swl_host_model_i (.ref_clk(ref_clk), .lineIn(lineIn), .hostPull(hostPull));
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [6:0] ad, input [7:0] v);
    begin
      swl_host_model_i.sendByte({1'b1, ad}, 8);
      swl_host_model_i.sendByte(v, 8);
      repeat (100) @(negedge ref_clk);
    end
  endtask
  task rc(input [6:0] ad, input [7:0] exp);
    reg [7:0] v;
    reg       ok;
    begin
      swl_host_model_i.sendByte({1'b0, ad}, 8);
      swl_host_model_i.getByte(v, ok);
      if (!ok) v = 8'hxx;
      check(v, exp);
      repeat (100) @(negedge ref_clk);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 140000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  initial begin
    #2;
    rst = 1'b1;
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    seed = xs(seed);
    a = seed[7:0];
    b = seed[15:8] & 8'hf7;
    voltageIn = seed[26:16];
    swl_host_model_i.brk;
    swl_host_model_i.sendByte(8'hf0, 3);
    swl_host_model_i.brk;
    wr(7'h6f, a);
    wr(7'h70, 8'h25);
    rc(7'h70, 8'h25);
    wr(7'h62, 8'h0f);
    rc(7'h25, a);
    wr(7'h6f, b);
    wr(7'h62, 8'h0f);
    rc(7'h25, a & b);
    wr(7'h70, 8'h45);
    wr(7'h62, 8'h0f);
    rc(7'h45, b);
    wr(7'h62, 8'h41);
    rc(7'h25, 8'hff);
    wr(7'h62, 8'h42);
    rc(7'h45, 8'hff);
    wr(7'h05, a);
    wr(7'h62, 8'h45);
    wr(7'h05, b);
    wr(7'h62, 8'h45);
    wr(7'h62, 8'h48);
    rc(7'h05, a & b);
    wr(7'h62, 8'h40);
    wr(7'h62, 8'h48);
    rc(7'h05, 8'hff);
    rc(7'h71, voltageIn[7:0]);
    rc(7'h72, {5'h13, voltageIn[10:8]});
    rc(7'h75, 8'h00);
    wr(7'h62, 8'hf6);
    check({7'h00, powerDown}, 8'h01);
    wr(7'h6f, a);
    check({7'h00, powerDown}, 8'h00);
    charging = 1'b0;
    discharging = 1'b0;
    wr(7'h63, 8'h10);
    rc(7'h65, 8'h00);
    wr(7'h63, 8'h08);
    rc(7'h63, 8'h00);
    rc(7'h67, 8'h00);
    finish_test;
  end
endmodule
bind swl_port swl_monitor #(.DSTART_CYC(DSTART_CYC), .DHOLD_CYC(DHOLD_CYC), .DCYCLE_CYC(DCYCLE_CYC)) swl_monitor_i (
  .ref_clk(ref_clk), .rst(rst), .lineIn(lineIn), .lineOut(lineOut), .lineOe_n(lineOe_n), .powerDown(powerDown));
